/* File: design/ua_uart_regs.vh */
`ifndef UA_UART_REGS_VH
`define UA_UART_REGS_VH
// Mode select field encodings
`define UA_MODE_ASYNC7     3'b100
`define UA_MODE_ASYNC8     3'b101
`define UA_MODE_ASYNC9     3'b110
// Prescaler selects for the baud divisor count source
`define UA_PRE_F1          2'b00
`define UA_PRE_F8          2'b01
`define UA_PRE_F32         2'b10
`define UA_PRE_F8_DIV      5'h07
`define UA_PRE_F32_DIV     5'h1f
// Flow control settings
`define UA_FLOW_CTS        2'b00
`define UA_FLOW_RTS        2'b01
`define UA_FLOW_OFF        2'b10
// Oversampling per bit
`define UA_OVS_LAST        4'hf
`define UA_OVS_MID         4'h7
// Reset value of idle line
`define UA_LINE_IDLE       1'b1
`endif

/* File: design/ua_uart_filt.v */
`default_nettype none
// ****************************************
// Receive input noise filter
// ****************************************
module ua_uart_filt (
  // Clock and reset
  input  wire i_clk,
  input  wire i_rst_n,
  // Control
  input  wire i_en,
  input  wire i_samp,
  // Data
  input  wire i_d,
  output reg  o_q
);
  reg [2:0] hist_reg;

  // Majority of three samples taken on the oversample strobe
  always @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      hist_reg <= 3'h7;
      o_q      <= 1'b1;
    end else begin
      if (i_samp) begin
        hist_reg <= {hist_reg[1:0], i_d};
      end
      if (!i_en) begin
        o_q <= i_d; // Bypass still costs one cycle, so the output stays registered
      end else begin
        o_q <= (hist_reg[0] & hist_reg[1]) | (hist_reg[1] & hist_reg[2]) |
               (hist_reg[0] & hist_reg[2]);
      end
    end
  end
endmodule // ua_uart_filt
`default_nettype wire

/* File: design/ua_uart.v */
// Function
// - Frames carry one start bit and seven, eight or nine data bits.
// - Parity bit after data is odd, even or absent.
// - Frame ends with one or two stop bits as configured.
// - Internal clock: rate is f1, f8 or f32 over 16 times divisor plus one.
// - External clock: rate is pin frequency over 16 times divisor plus one.
// - Flow control is CTS gating, RTS output, or none with pin freed.
// - Transmit starts only with tx allow set and buffer holding data.
// - With CTS gating, transmit waits until clear-to-send input is low.
// - Receive starts only with rx allow set and a start bit seen.
// - Source select 0: transmit request when buffer moves to shift register.
// - Source select 1: transmit request when shift register finishes sending.
// - Receive request when a character moves into the receive buffer.
// - Overrun when buffer unread and next char reaches bit before last stop.
// - Framing error when configured stop bits are not found.
// - Parity error when ones count disagrees with configured parity.
// - Summary error set when any overrun, framing or parity error occurs.
// - Software selects LSB-first or MSB-first bit order.
// - Data inversion flips data bits only, not start or stop bits.
// - Polarity inversion flips the output and input pins entirely.
// - Software enables or bypasses the receive noise filter.
// - Framing and parity flags set when character moves into receive buffer.
// - Mode field: 100b seven, 101b eight, 110b nine bit characters.
// - Serial output idles high, low with polarity inversion; open drain releases it only when high.
// - Receive buffer content is undefined after an overrun.
`default_nettype none
`include "ua_uart_regs.vh"
module ua_uart #(
  parameter BRG_W = 8
) (
  // Clock and reset
  input  wire             i_ref_clk,
  input  wire             i_rst_n,
  // Configuration
  input  wire [2:0]       i_mode_select_field,
  input  wire             i_clock_source_select,
  input  wire [1:0]       i_prescale_sel,
  input  wire [BRG_W-1:0] i_baud_divisor,
  input  wire             i_two_stop,
  input  wire             i_parity_en,
  input  wire             i_parity_even,
  input  wire             i_msb_first,
  input  wire             i_data_invert,
  input  wire             i_line_invert,
  input  wire             i_open_drain,
  input  wire             i_filter_en,
  input  wire [1:0]       i_flow_sel,
  input  wire             i_tx_irq_source_select,
  input  wire             i_tx_allow,
  input  wire             i_rx_allow,
  // Transmit buffer write port
  input  wire [8:0]       i_tx_buffer,
  input  wire             i_tx_write,
  // Receive buffer read port
  input  wire             i_rx_read,
  // Pins
  input  wire             i_ext_clock_pin,
  input  wire             i_serial_in_pin,
  input  wire             i_clear_to_send_input,
  output reg              o_tx_pin,
  output wire             o_tx_oe_n,
  output wire             o_rts_n,
  output wire             o_rts_oe_n,
  // Status
  output reg  [8:0]       o_rx_buffer,
  output reg              o_tx_buffer_empty_flag,
  output wire             o_tx_shift_empty,
  output reg              o_rx_full,
  output reg              o_overrun_err,
  output reg              o_framing_err,
  output reg              o_parity_err,
  output wire             o_error_sum,
  output reg              o_tx_irq,
  output reg              o_rx_irq
);
  // ****************************************
  // Reset and pin synchronisers
  // ****************************************
  reg [1:0] rst_sync_reg;
  reg [1:0] ext_sync_reg;
  reg [1:0] rxd_sync_reg;
  reg [1:0] cts_sync_reg;
  reg       ext_prev_reg;
  wire      rst_n = rst_sync_reg[1];

  // Release reset through two flops
  always @(posedge i_ref_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      rst_sync_reg <= 2'h0;
    end else begin
      rst_sync_reg <= {rst_sync_reg[0], 1'b1};
    end
  end

  // Pins cross two flops before use; only the second stage is read by logic
  always @(posedge i_ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      ext_sync_reg <= 2'h0;
      rxd_sync_reg <= 2'h3;
      cts_sync_reg <= 2'h3;
      ext_prev_reg <= 1'b0;
    end else begin
      ext_sync_reg <= {ext_sync_reg[0], i_ext_clock_pin};
      rxd_sync_reg <= {rxd_sync_reg[0], i_serial_in_pin};
      cts_sync_reg <= {cts_sync_reg[0], i_clear_to_send_input};
      ext_prev_reg <= ext_sync_reg[1];
    end
  end

  // ****************************************
  // Bit rate generation
  // ****************************************
  reg  [4:0]       pre_cnt_reg;
  reg  [BRG_W-1:0] brg_cnt_reg;
  wire             pre_tick;
  wire             src_tick;
  wire             ovs_tick;
  wire             ext_rise = ext_sync_reg[1] & ~ext_prev_reg;

  // Prescaler for f8 and f32
  always @(posedge i_ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      pre_cnt_reg <= 5'h00;
    end else begin
      pre_cnt_reg <= pre_cnt_reg + 5'h01;
    end
  end

  assign pre_tick = (i_prescale_sel == `UA_PRE_F1)  ? 1'b1 :
                    (i_prescale_sel == `UA_PRE_F8)  ?
                      ((pre_cnt_reg & `UA_PRE_F8_DIV) == `UA_PRE_F8_DIV) :
                      (pre_cnt_reg == `UA_PRE_F32_DIV);
  // External clock edges are counted; pin must be well below half the clock
  assign src_tick = i_clock_source_select ? ext_rise : pre_tick;

  // Divide by divisor plus one to give the 16x oversample strobe
  always @(posedge i_ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      brg_cnt_reg <= {BRG_W{1'b0}};
    end else if (src_tick) begin
      brg_cnt_reg <= (brg_cnt_reg == 0) ? i_baud_divisor : brg_cnt_reg - 1'b1;
    end
  end
  assign ovs_tick = src_tick & (brg_cnt_reg == 0);

  // ****************************************
  // Format decode
  // ****************************************
  wire       mode_ok = (i_mode_select_field == `UA_MODE_ASYNC7) |
                       (i_mode_select_field == `UA_MODE_ASYNC8) |
                       (i_mode_select_field == `UA_MODE_ASYNC9);
  wire [3:0] nbits   = (i_mode_select_field == `UA_MODE_ASYNC7) ? 4'h7 :
                       (i_mode_select_field == `UA_MODE_ASYNC9) ? 4'h9 : 4'h8;
  wire       cts_ok  = (i_flow_sel != `UA_FLOW_CTS) | ~cts_sync_reg[1];

  // Reorder for MSB first: only the low nbits take part
  function [8:0] ua_order;
    input [8:0] d;
    input [3:0] n;
    input       msb;
    integer k;
    begin
      ua_order = d;
      if (msb) begin
        for (k = 0; k < 9; k = k + 1) begin
          if (k < n) begin
            ua_order[k] = d[n - 1 - k];
          end
        end
      end
    end
  endfunction

  // ****************************************
  // Transmitter
  // ****************************************
  localparam TX_IDLE = 2'h0;
  localparam TX_RUN  = 2'h1;
  reg  [1:0] tx_st_reg;
  reg  [8:0] txb_reg;
  reg  [8:0] tx_sh_reg;
  reg  [3:0] tx_ovs_reg;
  reg  [3:0] tx_pos_reg;
  reg        tx_par_reg;
  wire [3:0] tx_last = nbits + {3'h0, i_parity_en} + {3'h0, i_two_stop} + 4'h1;
  reg        tx_bit;
  wire       tx_go = i_tx_allow & ~o_tx_buffer_empty_flag & cts_ok & mode_ok;

  assign o_tx_shift_empty = (tx_st_reg == TX_IDLE);
  assign o_tx_oe_n = i_open_drain & o_tx_pin;

  // Bit at the current position: start, data, parity, stop
  always @* begin
    if (tx_pos_reg == 4'h0) begin
      tx_bit = 1'b0;
    end else if (tx_pos_reg <= nbits) begin
      tx_bit = tx_sh_reg[0] ^ i_data_invert;
    end else if (i_parity_en && tx_pos_reg == nbits + 4'h1) begin
      tx_bit = tx_par_reg;
    end else begin
      tx_bit = 1'b1;
    end
  end

  // Frame sequencer; buffer write that meets a load keeps the new data
  always @(posedge i_ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      tx_st_reg <= TX_IDLE;
      txb_reg <= 9'h000;
      tx_sh_reg <= 9'h000;
      tx_ovs_reg <= 4'h0;
      tx_pos_reg <= 4'h0;
      tx_par_reg <= 1'b0;
      o_tx_buffer_empty_flag <= 1'b1;
      o_tx_pin <= `UA_LINE_IDLE;
      o_tx_irq <= 1'b0;
    end else begin
      o_tx_irq <= 1'b0;
      if (i_tx_write) begin
        txb_reg <= i_tx_buffer;
      end
      case (tx_st_reg)
        TX_IDLE: begin
          o_tx_pin <= `UA_LINE_IDLE ^ i_line_invert;
          if (tx_go && ovs_tick) begin
            tx_sh_reg <= ua_order(txb_reg, nbits, i_msb_first);
            tx_par_reg <= ~i_parity_even ^ (^(txb_reg & ~(9'h1ff << nbits)) ^
                          (i_data_invert & nbits[0]));
            tx_pos_reg <= 4'h0;
            tx_ovs_reg <= 4'h0;
            tx_st_reg <= TX_RUN;
            o_tx_irq <= ~i_tx_irq_source_select;
          end
          o_tx_buffer_empty_flag <= i_tx_write ? 1'b0 :
                                    ((tx_go && ovs_tick) ? 1'b1 : o_tx_buffer_empty_flag);
        end
        TX_RUN: begin
          o_tx_pin <= tx_bit ^ i_line_invert;
          if (i_tx_write) begin
            o_tx_buffer_empty_flag <= 1'b0;
          end
          if (ovs_tick) begin
            tx_ovs_reg <= tx_ovs_reg + 4'h1;
            if (tx_ovs_reg == `UA_OVS_LAST) begin
              if (tx_pos_reg >= 4'h1 && tx_pos_reg <= nbits) begin
                tx_sh_reg <= {1'b0, tx_sh_reg[8:1]};
              end
              if (tx_pos_reg == tx_last) begin
                tx_st_reg <= TX_IDLE;
                o_tx_irq <= i_tx_irq_source_select;
              end else begin
                tx_pos_reg <= tx_pos_reg + 4'h1;
              end
            end
          end
        end
        default: begin
          tx_st_reg <= TX_IDLE;
        end
      endcase
    end
  end

  // ****************************************
  // Receiver
  // ****************************************
  localparam RX_IDLE = 2'h0;
  localparam RX_RUN  = 2'h1;
  reg  [1:0] rx_st_reg;
  reg  [8:0] rx_sh_reg;
  reg  [3:0] rx_ovs_reg;
  reg  [3:0] rx_pos_reg;
  reg        rx_ones_reg;
  reg        rx_ferr_reg;
  reg        rx_oe_reg;
  wire       rxd_filt;
  wire       rxd = rxd_filt ^ i_line_invert;
  wire [3:0] rx_last = nbits + {3'h0, i_parity_en} + {3'h0, i_two_stop} + 4'h1;
  wire [8:0] rx_data = ua_order(rx_sh_reg >> (4'h9 - nbits), nbits, i_msb_first);

  // Optional majority filter on the synchronised input
  ua_uart_filt u_filt (
    .i_clk   (i_ref_clk),
    .i_rst_n (rst_n),
    .i_en    (i_filter_en),
    .i_samp  (ovs_tick),
    .i_d     (rxd_sync_reg[1]),
    .o_q     (rxd_filt)
  );

  // RTS asks for data while receiver is enabled and buffer is free
  assign o_rts_n    = ~(i_rx_allow & ~o_rx_full);
  assign o_rts_oe_n = (i_flow_sel != `UA_FLOW_RTS);
  assign o_error_sum = o_overrun_err | o_framing_err | o_parity_err;

  // Mid-bit sampling sequencer
  always @(posedge i_ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      rx_st_reg <= RX_IDLE;
      rx_sh_reg <= 9'h000;
      rx_ovs_reg <= 4'h0;
      rx_pos_reg <= 4'h0;
      rx_ones_reg <= 1'b0;
      rx_ferr_reg <= 1'b0;
      rx_oe_reg <= 1'b0;
      o_rx_buffer <= 9'h000;
      o_rx_full <= 1'b0;
      o_overrun_err <= 1'b0;
      o_framing_err <= 1'b0;
      o_parity_err <= 1'b0;
      o_rx_irq <= 1'b0;
    end else begin
      o_rx_irq <= 1'b0;
      if (i_rx_read) begin
        o_rx_full <= 1'b0;
        o_overrun_err <= 1'b0;
      end
      case (rx_st_reg)
        RX_IDLE: begin
          rx_ovs_reg <= 4'h0;
          if (ovs_tick && i_rx_allow && mode_ok && !rxd) begin
            rx_st_reg <= RX_RUN;
            rx_pos_reg <= 4'h0;
            rx_ones_reg <= 1'b0;
            rx_ferr_reg <= 1'b0;
            rx_oe_reg <= 1'b0;
            rx_ovs_reg <= 4'h1;
          end
        end
        RX_RUN: begin
          if (ovs_tick) begin
            rx_ovs_reg <= rx_ovs_reg + 4'h1;
            if (rx_ovs_reg == `UA_OVS_MID) begin
              if (rx_pos_reg == 4'h0) begin
                if (rxd) begin
                  rx_st_reg <= RX_IDLE;
                end
              end else if (rx_pos_reg <= nbits) begin
                rx_sh_reg <= {rxd ^ i_data_invert, rx_sh_reg[8:1]};
                rx_ones_reg <= rx_ones_reg ^ rxd;
              end else if (i_parity_en && rx_pos_reg == nbits + 4'h1) begin
                rx_ones_reg <= rx_ones_reg ^ rxd;
              end else if (!rxd) begin
                rx_ferr_reg <= 1'b1;
              end
              // Still unread when the bit before the last stop is in
              if (rx_pos_reg == rx_last - 4'h1 && (o_rx_full && !i_rx_read)) begin
                rx_oe_reg <= 1'b1;
              end
              if (rx_pos_reg == rx_last) begin
                rx_st_reg <= RX_IDLE;
                // Buffer overwritten anyway on overrun; content undefined
                o_rx_buffer <= rx_data;
                o_rx_full <= 1'b1;
                o_rx_irq <= 1'b1;
                o_framing_err <= rx_ferr_reg | ~rxd;
                // Ones are counted on line bits, so data inversion needs no term here
                o_parity_err <= i_parity_en & (rx_ones_reg ^ ~i_parity_even);
                o_overrun_err <= o_overrun_err | rx_oe_reg;
              end else if (rx_pos_reg != 4'h0 || !rxd) begin
                rx_pos_reg <= rx_pos_reg + 4'h1;
              end
            end
          end
        end
        default: begin
          rx_st_reg <= RX_IDLE;
        end
      endcase
    end
  end
endmodule // ua_uart
`default_nettype wire

/* File: testbench/ua_uart_monitor.sv */
`default_nettype none
// ***
// Port checks for the serial channel
// ***
module ua_uart_monitor (
  // Clock and reset
  input wire logic       i_ref_clk,
  input wire logic       i_rst_n,
  // Controls
  input wire logic [1:0] i_flow_sel,
  input wire logic       i_clear_to_send_input,
  input wire logic       i_tx_allow,
  input wire logic       i_tx_irq_source_select,
  input wire logic       i_line_invert,
  input wire logic       i_open_drain,
  input wire logic       i_tx_write,
  input wire logic       i_rx_read,
  // Observed outputs
  input wire logic       o_tx_pin,
  input wire logic       o_tx_oe_n,
  input wire logic       o_rts_oe_n,
  input wire logic       o_tx_buffer_empty_flag,
  input wire logic       o_tx_shift_empty,
  input wire logic       o_rx_full,
  input wire logic       o_overrun_err,
  input wire logic       o_framing_err,
  input wire logic       o_parity_err,
  input wire logic       o_error_sum,
  input wire logic       o_tx_irq,
  input wire logic       o_rx_irq
);
  timeunit 1ns;
  timeprecision 1ns;
  // One domain, so one clocking and one disable serve every check
  default clocking mon_cb @(posedge i_ref_clk);
  endclocking
  default disable iff (!i_rst_n);

  tx_allow_a : assert property (
    $fell(o_tx_shift_empty) |-> $past(i_tx_allow)) else $error("load without tx allow");
  cts_gate_a : assert property (
    ($fell(o_tx_shift_empty) && i_flow_sel == 2'h0) |-> !$past(i_clear_to_send_input))
    else $error("load while clear to send is high");
  irq_load_a : assert property (
    ($fell(o_tx_shift_empty) && !i_tx_irq_source_select) |-> ##[0:1] o_tx_irq)
    else $error("no tx request at load");
  irq_done_a : assert property (
    ($rose(o_tx_shift_empty) && i_tx_irq_source_select) |-> ##[0:1] o_tx_irq)
    else $error("no tx request at completion");
  irq_pulse_a : assert property (
    o_tx_irq |=> !o_tx_irq) else $error("tx request longer than one cycle");
  rx_full_a : assert property (
    o_rx_irq |-> o_rx_full) else $error("rx request without full buffer");
  read_clr_a : assert property (
    i_rx_read |=> (!o_rx_full || o_rx_irq)) else $error("read did not empty buffer");
  err_load_a : assert property (
    ($rose(o_framing_err) || $rose(o_parity_err)) |-> o_rx_irq)
    else $error("error flag set away from buffer load");
  err_sum_a : assert property (
    o_error_sum == (o_overrun_err || o_framing_err || o_parity_err))
    else $error("summary flag mismatch");
  wr_empty_a : assert property (
    i_tx_write |=> !o_tx_buffer_empty_flag) else $error("write left buffer empty");
  line_idle_a : assert property (
    (o_tx_shift_empty && $past(o_tx_shift_empty) && $stable(i_line_invert))
    |-> o_tx_pin == !i_line_invert) else $error("idle level wrong");
  drain_oe_a : assert property (
    o_tx_oe_n == (i_open_drain && o_tx_pin)) else $error("output enable wrong");
  rts_oe_a : assert property (
    $stable(i_flow_sel) |-> o_rts_oe_n == (i_flow_sel != 2'h1))
    else $error("ready pin enable wrong");
endmodule // ua_uart_monitor

bind ua_uart ua_uart_monitor mon_u (
  .i_ref_clk, .i_rst_n, .i_flow_sel, .i_clear_to_send_input, .i_tx_allow,
  .i_tx_irq_source_select, .i_line_invert, .i_open_drain, .i_tx_write, .i_rx_read,
  .o_tx_pin, .o_tx_oe_n, .o_rts_oe_n, .o_tx_buffer_empty_flag, .o_tx_shift_empty,
  .o_rx_full, .o_overrun_err, .o_framing_err, .o_parity_err, .o_error_sum,
  .o_tx_irq, .o_rx_irq);
`default_nettype wire

/* File: testbench/ua_remote.sv */
`default_nettype none
// ***
// Remote transceiver at the far end of the lines
// ***
module ua_remote (
  // Clock
  input  wire logic i_clk,
  // Lines
  input  wire logic i_line,
  output wire logic o_line,
  output var  logic o_cts_n
);
  timeunit 1ns;
  timeprecision 1ns;
  int          bit_cyc = 32;
  int          rx_len  = 10;
  int          rx_cnt  = 0;
  logic        inv     = 1'b0;
  logic        lvl     = 1'b1;
  logic [12:0] got     = 13'h0000;
  // Polarity flips every bit of the frame
  assign o_line = lvl ^ inv;
  // Held high until the bench lets the channel send
  initial o_cts_n = 1'b1;
  // Mid-bit capture; a low shorter than half a bit is a glitch
  always @(posedge i_clk) begin
    if (!(i_line ^ inv)) begin
      repeat (bit_cyc / 2 - 1) @(posedge i_clk);
      if (!(i_line ^ inv)) begin
        for (int i = 0; i < rx_len; i++) begin
          if (i > 0) repeat (bit_cyc) @(posedge i_clk);
          got[i] = i_line ^ inv;
        end
        rx_cnt++;
      end
    end
  end
  // Whole frame, start bit first, then back to idle
  task automatic send(input logic [12:0] f, input int len);
    for (int i = 0; i < len; i++) begin
      lvl <= f[i];
      repeat (bit_cyc) @(posedge i_clk);
    end
    lvl <= 1'b1;
  endtask
endmodule // ua_remote
`default_nettype wire

/* File: testbench/ua_uart_test.sv */
`default_nettype none
// ***
// Self-checking bench for the serial channel
// ***
module ua_uart_test;
  timeunit 1ns;
  timeprecision 1ns;
  // Data, mode, clock source (3 means the pin), flow, then option bits
  typedef struct packed {
    logic [8:0] d;
    logic [2:0] mode;
    logic [1:0] pre;
    logic [1:0] flow;
    logic       msb, dinv, pen, peven, two, linv, filt, isel;
  } ua_row_t;
  ua_row_t rows [6] = '{
    {9'h0a5, 3'h5, 2'h0, 2'h2, 8'h00}, {9'h05a, 3'h4, 2'h0, 2'h3, 8'h39},
    {9'h1c3, 3'h6, 2'h0, 2'h1, 8'h22}, {9'h03c, 3'h5, 2'h1, 2'h2, 8'hf1},
    {9'h081, 3'h5, 2'h3, 2'h2, 8'h26}, {9'h013, 3'h4, 2'h2, 2'h3, 8'h68}};
  logic        i_ref_clk = 1'b0, i_rst_n = 1'b0, i_ext_clock_pin = 1'b0;
  logic [2:0]  i_mode_select_field = 3'h5;
  logic [1:0]  i_prescale_sel = 2'h0, i_flow_sel = 2'h2;
  logic [7:0]  i_baud_divisor = 8'h01;
  logic [8:0]  i_tx_buffer = 9'h000;
  logic        i_clock_source_select = 0, i_two_stop = 0, i_parity_en = 0, i_parity_even = 0;
  logic        i_msb_first = 0, i_data_invert = 0, i_line_invert = 0, i_open_drain = 0;
  logic        i_filter_en = 0, i_tx_irq_source_select = 0, i_tx_allow = 1, i_rx_allow = 0;
  logic        i_tx_write = 0, i_rx_read = 0;
  wire logic   i_serial_in_pin, i_clear_to_send_input, tx_line;
  logic [8:0]  o_rx_buffer, exp_d;
  logic        o_tx_pin, o_tx_oe_n, o_tx_buffer_empty_flag, o_tx_shift_empty, o_rx_full, o_rts_n;
  logic        o_overrun_err, o_framing_err, o_parity_err, o_error_sum, o_tx_irq, o_rx_irq;
  logic [12:0] exp_f;
  ua_row_t     row;
  int          err_total = 0, num_checks = 0, bit_cyc = 32, len = 10, n0, t0, tx_n = 0, rx_n = 0;

  ua_uart dut_u (.i_ref_clk, .i_rst_n, .i_mode_select_field, .i_clock_source_select,
    .i_prescale_sel, .i_baud_divisor, .i_two_stop, .i_parity_en, .i_parity_even, .i_msb_first,
    .i_data_invert, .i_line_invert, .i_open_drain, .i_filter_en, .i_flow_sel,
    .i_tx_irq_source_select, .i_tx_allow, .i_rx_allow, .i_tx_buffer, .i_tx_write, .i_rx_read,
    .i_ext_clock_pin, .i_serial_in_pin, .i_clear_to_send_input, .o_tx_pin, .o_tx_oe_n,
    .o_rts_n, .o_rts_oe_n(), .o_rx_buffer, .o_tx_buffer_empty_flag, .o_tx_shift_empty,
    .o_rx_full, .o_overrun_err, .o_framing_err, .o_parity_err, .o_error_sum, .o_tx_irq,
    .o_rx_irq);
  ua_remote partner_u (.i_clk(i_ref_clk), .i_line(tx_line), .o_line(i_serial_in_pin),
    .o_cts_n(i_clear_to_send_input));

  // Open drain line has a pull-up while released
  assign tx_line = o_tx_oe_n ? 1'b1 : o_tx_pin;
  // Clocks; the pin clock is four system cycles and in fixed phase with the system clock
  always #50 i_ref_clk = ~i_ref_clk;
  always #200 i_ext_clock_pin = ~i_ext_clock_pin;
  // Count one-cycle request pulses
  always @(posedge i_ref_clk) begin
    tx_n <= tx_n + (o_tx_irq === 1'b1);
    rx_n <= rx_n + (o_rx_irq === 1'b1);
  end

  task automatic check(input string what, input logic [12:0] seen, input logic [12:0] want);
    num_checks++;
    if (seen !== want) begin
      err_total++;
      $display("BAD %s expected %h seen %h", what, want, seen);
    end
  endtask
  task automatic print_verdict;
    if (err_total == 0 && num_checks > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask
  // Frame as it should appear on the line, bit 0 sent first
  function automatic logic [12:0] mk(input ua_row_t r);
    logic [12:0] f;
    logic        p;
    int          nb;
    nb = 7 + r.mode[1:0];
    f = 13'h1ffe;
    p = 1'b0;
    for (int i = 0; i < nb; i++) begin
      f[i + 1] = (r.msb ? r.d[nb - 1 - i] : r.d[i]) ^ r.dinv;
      p ^= f[i + 1];
    end
    if (r.pen) f[nb + 1] = p ^ !r.peven;
    len = nb + 2 + r.pen + r.two;
    exp_d = r.d & ((9'h001 << nb) - 9'h001);
    return f & ((13'h0001 << len) - 13'h0001);
  endfunction
  // Reception is held off while the format changes, so no glitch is taken
  task automatic apply(input ua_row_t r);
    int mul [4] = '{1, 8, 32, 4};
    @(posedge i_ref_clk);
    #10;
    i_rx_allow = 0;
    {i_mode_select_field, i_msb_first, i_data_invert, i_parity_en} = {r.mode, r.msb, r.dinv, r.pen};
    {i_parity_even, i_two_stop, i_line_invert, i_filter_en} = {r.peven, r.two, r.linv, r.filt};
    {i_tx_irq_source_select, i_flow_sel, i_clock_source_select} = {r.isel, r.flow, &r.pre};
    i_prescale_sel = &r.pre ? 2'h0 : r.pre;
    bit_cyc = 32 * mul[r.pre];
    exp_f = mk(r);
    partner_u.inv = r.linv;
    partner_u.bit_cyc = bit_cyc;
    partner_u.rx_len = len;
    repeat (bit_cyc) @(posedge i_ref_clk);
    #10;
    i_rx_allow = 1;
  endtask
  task automatic pulse(input logic wr, input logic [8:0] d);
    @(posedge i_ref_clk);
    #10;
    {i_tx_buffer, i_tx_write, i_rx_read} = {d, wr, !wr};
    @(posedge i_ref_clk);
    #10;
    {i_tx_write, i_rx_read} = 2'h0;
  endtask
  task automatic tx_chk;
    int w;
    for (w = 0; w < 16 * bit_cyc && partner_u.rx_cnt == n0; w++) @(posedge i_ref_clk);
    repeat (bit_cyc) @(posedge i_ref_clk);
    check("frames", partner_u.rx_cnt - n0, 13'h0001);
    check("tx line", partner_u.got & ((13'h0001 << len) - 13'h0001), exp_f);
  endtask
  task automatic rx_chk(input logic [12:0] f, input logic [2:0] err, input logic rd);
    int r0;
    r0 = rx_n;
    partner_u.send(f, len);
    repeat (4) @(posedge i_ref_clk);
    if (!err[2]) check("rx irq", rx_n - r0, 13'h0001);
    if (!err) check("rx data", o_rx_buffer, exp_d);
    check("errors", {o_overrun_err, o_framing_err, o_parity_err, o_error_sum}, {err, |err});
    if (rd) pulse(1'b0, 9'h000);
    if (rd) check("rx empty", {o_rx_full, o_overrun_err, o_rts_n}, 13'h0000);
  endtask

  // Watchdog, about twice the expected run of some 40000 cycles
  initial begin
    repeat (80000) @(posedge i_ref_clk);
    err_total++;
    print_verdict;
  end
  // Main sequence
  initial begin
    repeat (3) @(posedge i_ref_clk);
    #10;
    i_rst_n = 1;
    repeat (3) @(posedge i_ref_clk);
    check("reset",
      {o_tx_pin, o_tx_buffer_empty_flag, o_tx_shift_empty, o_rx_full, o_error_sum}, 13'h001c);
    foreach (rows[k]) begin
      apply(rows[k]);
      n0 = partner_u.rx_cnt;
      t0 = tx_n;
      pulse(1'b1, rows[k].d);
      tx_chk;
      check("tx irq", tx_n - t0, 13'h0001);
      rx_chk(exp_f, 3'h0, 1'b1);
    end
    // Clear to send gating, with the output in open drain; two stops let the
    // framing case break the first stop and still leave the line idle after it
    row = rows[0];
    {row.flow, row.pen, row.peven, row.two} = {2'h0, 3'h7};
    apply(row);
    i_open_drain = 1;
    n0 = partner_u.rx_cnt;
    pulse(1'b1, row.d);
    repeat (4 * bit_cyc) @(posedge i_ref_clk);
    check("no cts", {o_tx_shift_empty, o_tx_oe_n, partner_u.rx_cnt == n0}, 13'h0007);
    #10;
    partner_u.o_cts_n = 0;
    tx_chk;
    // Transmit allow off holds the buffer
    #10;
    i_tx_allow = 0;
    n0 = partner_u.rx_cnt;
    pulse(1'b1, row.d);
    repeat (3 * bit_cyc) @(posedge i_ref_clk);
    check("allow hold", {o_tx_buffer_empty_flag, partner_u.rx_cnt == n0}, 13'h0001);
    // A mode code outside the three character lengths still holds it
    #10;
    {i_tx_allow, i_mode_select_field} = {1'b1, 3'h0};
    repeat (3 * bit_cyc) @(posedge i_ref_clk);
    check("mode hold", {o_tx_buffer_empty_flag, partner_u.rx_cnt == n0}, 13'h0001);
    #10;
    i_mode_select_field = row.mode;
    tx_chk;
    // Receive allow off ignores a whole frame
    #10;
    i_rx_allow = 0;
    t0 = rx_n;
    partner_u.send(exp_f, len);
    check("rx ignored", {rx_n - t0, o_rx_full}, 13'h0000);
    #10;
    i_rx_allow = 1;
    rx_chk(exp_f ^ (13'h0001 << 9), 3'h1, 1'b1);
    rx_chk(exp_f & ~(13'h0001 << 10), 3'h2, 1'b1);
    rx_chk(exp_f, 3'h0, 1'b0);
    rx_chk(exp_f, 3'h4, 1'b1);
    print_verdict;
  end
endmodule // ua_uart_test
`default_nettype wire
